// file: common/upfc_regs.vh
// Purpose: Register offsets, field positions, reset values and codes
//          for the paged FIFO and flow-control block of one UART channel.
// Assumes: Byte-wide registers on a 3-bit register address.
// Notes:   Included by the design files; definitions only.
`ifndef UPFC_REGS_VH
`define UPFC_REGS_VH

// ----------------------------------------------------------------------
// Base page offsets
// ----------------------------------------------------------------------
`define UPFC_OFF_DATA 3'h0
`define UPFC_OFF_IER 3'h1
`define UPFC_OFF_FCR_ISR 3'h2
`define UPFC_OFF_LCR 3'h3
`define UPFC_OFF_MCR 3'h4
`define UPFC_OFF_LSR 3'h5
`define UPFC_OFF_MSR 3'h6
`define UPFC_OFF_SPR 3'h7

// ----------------------------------------------------------------------
// Alternate (flow) page offsets
// ----------------------------------------------------------------------
`define UPFC_OFF_TXCNT 3'h0
`define UPFC_OFF_RXCNT 3'h1
`define UPFC_OFF_FSR 3'h2
`define UPFC_OFF_IRQ_STAT 3'h5
`define UPFC_OFF_IRQ_MASK 3'h6

// ----------------------------------------------------------------------
// Extended page offsets
// ----------------------------------------------------------------------
`define UPFC_OFF_EFR 3'h2
`define UPFC_OFF_PSR 3'h4
`define UPFC_OFF_AFR 3'h0
`define UPFC_OFF_TTR 3'h5
`define UPFC_OFF_RTR 3'h6
`define UPFC_OFF_FUR 3'h7
`define UPFC_OFF_FLR 3'h1

// ----------------------------------------------------------------------
// Codes and field positions
// ----------------------------------------------------------------------
`define UPFC_LCR_EXT 8'hBF
`define UPFC_PSR_OPEN 8'hA5
`define UPFC_PSR_CLOSE 8'hA4
`define UPFC_AFR_256 8'h01
`define UPFC_FCR_EN 0
`define UPFC_LCR_DLAB 7
`define UPFC_MCR_XOFF 2
`define UPFC_MCR_ALT 6
`define UPFC_MCR_PRESC 7
`define UPFC_EFR_ENH 4
`define UPFC_EFR_SWTX 3
`define UPFC_EFR_ARTS 6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UPFC_RST_ZERO 8'h00
`define UPFC_RST_TRIG 8'h80
`define UPFC_RST_ISR 8'h01

// ----------------------------------------------------------------------
// Fixed 64-byte trigger levels
// ----------------------------------------------------------------------
`define UPFC_RX_T0 9'h008
`define UPFC_RX_T1 9'h010
`define UPFC_RX_T2 9'h038
`define UPFC_RX_T3 9'h03C
`define UPFC_TX_T0 9'h008
`define UPFC_TX_T1 9'h010
`define UPFC_TX_T2 9'h020
`define UPFC_TX_T3 9'h038

`endif

// file: dv/testbench.sv
// Purpose: Self-checking bench for the paged FIFO register block.
// Assumes: Host port with one-cycle strobes and read data a cycle later.
// Notes:   Table of small-mode triggers first, then paged sequences.
`timescale 1ns/100ps

module testbench;
    logic ref_clk = 1'b0; // Clock.
    logic rst_n = 1'b0; // Reset, active low.
    logic [2:0] reg_addr = 3'h0; // Address.
    logic [7:0] reg_wdata = 8'h00; // Write data.
    logic reg_wr = 1'b0; // Write strobe.
    logic reg_rd = 1'b0; // Read strobe.
    logic [8:0] tx_count = 9'h050; // TX fill, above any level set.
    logic [8:0] rx_count = 9'h000; // RX fill.
    logic [7:0] flow_status = 8'h3C; // Flow status seen on read.
    logic tx_empty = 1'b0; // TX empty.
    logic rx_full = 1'b0; // RX full.
    logic [7:0] base_rdata = 8'h5A; // Base register data.
    wire [7:0] reg_rdata, flow_upper, flow_lower;
    wire [8:0] tx_level, rx_level;
    wire fifo_en, mode_256, xoff_resend, presc_div4, base_wr, base_rd, irq;
    int n_fail = 0; // Mismatch count.
    int checked = 0; // Comparison count.
    typedef struct packed {logic [7:0] f; logic [8:0] r; logic [8:0] t;}
        upfc_row_t;
    // Control byte beside the RX and TX levels that it should give.
    upfc_row_t rows [4] = '{'{8'h01, 9'h008, 9'h008},
        '{8'h51, 9'h010, 9'h010}, '{8'hA1, 9'h038, 9'h020},
        '{8'hF1, 9'h03C, 9'h038}};

    upfc_core upfc_core_inst (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .tx_count, .rx_count, .flow_status,
        .tx_empty, .rx_full, .fifo_en, .mode_256, .tx_level, .rx_level,
        .flow_upper, .flow_lower, .xoff_resend, .presc_div4, .base_wr,
        .base_rd, .base_rdata, .irq);

    // Free-running 100 MHz clock.
    initial forever #5 ref_clk = ~ref_clk;

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle write; outputs are settled on return.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // One-cycle write that also looks at the forwarded base strobe.
    task automatic wrb(input logic [2:0] a, input logic [7:0] d,
        input logic eb);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        #1;
        chk(base_wr, eb);
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // One-cycle read; data is looked at in the following cycle only.
    task automatic rd(input logic [2:0] a, input logic [7:0] e,
        input logic eb);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        #1;
        chk(base_rd, eb);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    // Hold reset four cycles and look at the reset state inside it.
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk({fifo_en, mode_256, irq, presc_div4}, 9'h000);
        chk(tx_level, 9'h008);
        chk(rx_level, 9'h008);
        chk(flow_upper, 9'h000);
        chk(reg_rdata, 9'h000);
        rst_n <= 1'b1;
    endtask

    task automatic complete_run;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // A hang counts as a mismatch and closes the run.
    initial
    begin
        #200000;
        n_fail++;
        complete_run;
    end

    initial
    begin
        do_reset;
        foreach (rows[i])
        begin
            wrb(3'h2, rows[i].f, 1'b1);
            chk(rx_level, rows[i].r);
            chk(tx_level, rows[i].t);
        end
        wr(3'h2, 8'hF0);
        chk(fifo_en, 1'b0);
        wr(3'h2, 8'h01);
        wr(3'h4, 8'h80);
        chk(presc_div4, 1'b0);
        // Open the extended page with enhanced and flow bits set.
        wr(3'h3, 8'hBF);
        wr(3'h2, 8'h18);
        wr(3'h4, 8'hA5);
        wr(3'h0, 8'h01);
        chk(mode_256, 1'b1);
        rd(3'h0, 8'h01, 1'b0);
        wr(3'h5, 8'h20);
        wr(3'h6, 8'h80);
        chk(tx_level, 9'h020);
        chk(rx_level, 9'h080);
        wr(3'h7, 8'h40);
        chk(flow_upper, 8'h40);
        wr(3'h1, 8'h50);
        chk(flow_lower, 8'h00);
        wr(3'h1, 8'h10);
        chk(flow_lower, 8'h10);
        wr(3'h4, 8'hA4);
        rd(3'h0, 8'h00, 1'b0);
        wr(3'h3, 8'h03);
        tx_empty <= 1'b1;
        rx_full <= 1'b1;
        rd(3'h2, 8'hDA, 1'b1);
        rd(3'h7, 8'h5A, 1'b1);
        wr(3'h4, 8'h80);
        chk(presc_div4, 1'b1);
        // Alternate page: counts, flow status and the interrupt.
        tx_empty <= 1'b0;
        rx_full <= 1'b0;
        wr(3'h4, 8'hC0);
        rd(3'h0, 8'h50, 1'b0);
        rd(3'h2, 8'h3C, 1'b0);
        rd(3'h7, 8'h00, 1'b0);
        wrb(3'h5, 8'h0F, 1'b0);
        rd(3'h5, 8'h00, 1'b0);
        wr(3'h6, 8'h02);
        rx_count <= 9'h100;
        rd(3'h1, 8'hFF, 1'b0);
        chk(irq, 1'b1);
        tx_count <= 9'h010;
        rd(3'h5, 8'h03, 1'b0);
        chk(irq, 1'b1);
        wr(3'h5, 8'h02);
        chk(irq, 1'b0);
        rd(3'h5, 8'h01, 1'b0);
        wr(3'h4, 8'hC4);
        chk(xoff_resend, 1'b1);
        wr(3'h4, 8'hC0);
        chk(xoff_resend, 1'b0);
        wr(3'h4, 8'h80);
        wr(3'h3, 8'h03);
        rd(3'h0, 8'h5A, 1'b1);
        do_reset;
        complete_run;
    end
endmodule

// file: dv/upfc_core_chk.sv
// Purpose: Port-level checks for the paged FIFO register block.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to every upfc_core instance below the module.
`timescale 1ns/100ps

module upfc_chk
#(
    parameter CNT_W = 9 // Width of FIFO entry counts.
)
(
    input wire ref_clk, // Clock.
    input wire rst_n, // Reset, active low.
    input wire [2:0] reg_addr, // Address.
    input wire [7:0] reg_wdata, // Write data.
    input wire reg_wr, // Write strobe.
    input wire reg_rd, // Read strobe.
    input wire [7:0] reg_rdata, // Read data.
    input wire [CNT_W-1:0] tx_count, // TX fill.
    input wire [CNT_W-1:0] rx_count, // RX fill.
    input wire [7:0] flow_status, // Flow status.
    input wire tx_empty, // TX empty.
    input wire rx_full, // RX full.
    input wire fifo_en, // FIFOs on.
    input wire mode_256, // Large mode.
    input wire [8:0] tx_level, // TX level.
    input wire [8:0] rx_level, // RX level.
    input wire [7:0] flow_upper, // Upper threshold.
    input wire [7:0] flow_lower, // Lower threshold.
    input wire xoff_resend, // Xoff resend.
    input wire presc_div4, // Prescaler.
    input wire base_wr, // Base write.
    input wire base_rd, // Base read.
    input wire [7:0] base_rdata, // Base data.
    input wire irq // Interrupt.
);
    // One domain, so clock and reset are given once for all checks.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a read");
    property p_base_src;
        (base_rd |-> reg_rd) and (base_wr |-> reg_wr);
    endproperty
    a_base_src: assert property (p_base_src)
        else $error("base strobe without host strobe");
    property p_base_data;
        base_rd && !(reg_addr inside {3'h2, 3'h3, 3'h4})
            |=> reg_rdata == $past(base_rdata);
    endproperty
    a_base_data: assert property (p_base_data)
        else $error("base read data not passed through");
    property p_stat_256;
        base_rd && reg_addr == 3'h2 && mode_256 |=> reg_rdata ==
            {$past(tx_empty), $past(rx_full), $past(base_rdata[5:0])};
    endproperty
    a_stat_256: assert property (p_stat_256)
        else $error("large-mode status bits wrong");
    property p_mode_en;
        mode_256 |-> fifo_en;
    endproperty
    a_mode_en: assert property (p_mode_en)
        else $error("large mode without FIFO enable");
    property p_lvl_64;
        fifo_en && !mode_256 |-> rx_level inside {9'h008, 9'h010,
            9'h038, 9'h03C} && tx_level inside {9'h008, 9'h010,
            9'h020, 9'h038};
    endproperty
    a_lvl_64: assert property (p_lvl_64)
        else $error("small-mode trigger level off table");
    property p_low_below;
        mode_256 && $past(mode_256) && flow_lower != $past(flow_lower)
            |-> flow_lower < flow_upper;
    endproperty
    a_low_below: assert property (p_low_below)
        else $error("lower threshold not below upper");
    property p_low_64;
        !mode_256 |-> flow_lower == rx_level[7:0];
    endproperty
    a_low_64: assert property (p_low_64)
        else $error("small-mode lower threshold not RX level");
    property p_hold;
        !$past(reg_wr) |-> $stable({fifo_en, mode_256, flow_upper,
            xoff_resend, presc_div4, tx_level, rx_level});
    endproperty
    a_hold: assert property (p_hold)
        else $error("control output moved without a write");
endmodule

bind upfc_core upfc_chk #(.CNT_W(CNT_W)) upfc_chk_inst (.ref_clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_count,
    .rx_count, .flow_status, .tx_empty, .rx_full, .fifo_en, .mode_256,
    .tx_level, .rx_level, .flow_upper, .flow_lower, .xoff_resend,
    .presc_div4, .base_wr, .base_rd, .base_rdata, .irq);

// file: logic/upfc_core.v
// Purpose: Paged register file for one UART channel's FIFO extensions.
// Assumes: One clock; count and fill inputs come from same-clock logic.
// Notes:   Serial framing and baud generation sit outside this block.
`timescale 1ns/100ps
`include "upfc_regs.vh"

module upfc_core
#(
    parameter CNT_W = 9 // Width of FIFO entry counts.
)
(
    ref_clk, // System clock, 100 MHz.
    rst_n, // Asynchronous reset, active low.
    reg_addr, // Register address.
    reg_wdata, // Write data.
    reg_wr, // Write strobe.
    reg_rd, // Read strobe.
    reg_rdata, // Read data, one cycle after strobe.
    tx_count, // TX FIFO entries.
    rx_count, // RX FIFO entries.
    flow_status, // Flow-control status bits.
    tx_empty, // TX FIFO empty.
    rx_full, // RX FIFO full.
    fifo_en, // FIFOs enabled.
    mode_256, // 256-byte mode active.
    tx_level, // Active TX trigger level.
    rx_level, // Active RX trigger level.
    flow_upper, // Upper flow threshold.
    flow_lower, // Lower flow threshold.
    xoff_resend, // Xoff re-transmission enable.
    presc_div4, // Prescaler divides by 4.
    base_wr, // Write to base register passed on.
    base_rd, // Read of base register passed on.
    base_rdata, // Data from base registers.
    irq // Level interrupt output.
);
    input wire ref_clk;
    input wire rst_n;
    input wire [2:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [7:0] reg_rdata;
    input wire [CNT_W-1:0] tx_count;
    input wire [CNT_W-1:0] rx_count;
    input wire [7:0] flow_status;
    input wire tx_empty;
    input wire rx_full;
    output wire fifo_en;
    output wire mode_256;
    output wire [8:0] tx_level;
    output wire [8:0] rx_level;
    output wire [7:0] flow_upper;
    output wire [7:0] flow_lower;
    output wire xoff_resend;
    output wire presc_div4;
    output wire base_wr;
    output wire base_rd;
    input wire [7:0] base_rdata;
    output wire irq;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    reg [7:0] fcr_q; // FIFO control register.
    reg [7:0] lcr_q; // Line control register.
    reg [7:0] mcr_q; // Modem control register.
    reg [7:0] efr_q; // Enhanced feature register.
    reg page_open_q; // Extended page opened by page select.
    reg [7:0] afr_q; // FIFO mode register.
    reg [7:0] ttr_q; // TX trigger level register.
    reg [7:0] rtr_q; // RX trigger level register.
    reg [7:0] fur_q; // Upper threshold.
    reg [7:0] flr_q; // Lower threshold.
    reg [7:0] xon_q; // Xoff re-transmit enable register.
    reg [3:0] ists_q; // Sticky interrupt status.
    reg [3:0] imsk_q; // Interrupt mask.
    reg tx_trig_q; // Previous TX trigger state.
    reg rx_trig_q; // Previous RX trigger state.
    reg [7:0] rdata_d; // Next read data.
    wire tx_trig; // TX trigger condition.
    wire rx_trig; // RX trigger condition.
    wire [8:0] txc9; // TX count at nine bits.
    wire [8:0] rxc9; // RX count at nine bits.
    wire lcr_ext; // Line control holds the extended code.
    wire ext_sel; // Extended page selected.
    wire alt_sel; // Alternate flow page selected.
    wire wr_ext; // Write to the extended page.
    wire wr_alt; // Write to the alternate page.
    wire [3:0] ev; // Trigger edge pulses and empty/full levels.

    // Saturate a count to one byte for an 8-bit read.
    function [7:0] sat8;
        input [8:0] v;
        begin
            sat8 = v[8] ? 8'hFF : v[7:0];
        end
    endfunction

    assign txc9 = tx_count;
    assign rxc9 = rx_count;

    // ------------------------------------------------------------------
    // Page decode
    // ------------------------------------------------------------------
    // extended page gate
    assign lcr_ext = (lcr_q == `UPFC_LCR_EXT);
    assign ext_sel = lcr_ext && page_open_q;
    assign alt_sel = !lcr_q[`UPFC_LCR_DLAB] && mcr_q[`UPFC_MCR_ALT];
    assign wr_ext = reg_wr && ext_sel;
    assign wr_alt = reg_wr && alt_sel;
    assign base_wr = reg_wr && !lcr_ext && !alt_sel;
    assign base_rd = reg_rd && !lcr_ext && !alt_sel;

    assign fifo_en = fcr_q[`UPFC_FCR_EN];
    assign mode_256 = fifo_en && (afr_q == `UPFC_AFR_256);
    assign flow_upper = fur_q;
    // Lower threshold follows the RX trigger in 64-byte mode.
    assign flow_lower = mode_256 ? flr_q : rx_level[7:0];
    assign xoff_resend = xon_q[0];
    assign presc_div4 = mcr_q[`UPFC_MCR_PRESC];

    // ------------------------------------------------------------------
    // Trigger levels
    // ------------------------------------------------------------------
    upfc_level upfc_level_inst
    (
        .fcr_top(fcr_q[7:4]),
        .fifo_en(fifo_en),
        .mode_256(mode_256),
        .ttr_val(ttr_q),
        .rtr_val(rtr_q),
        .tx_count(txc9),
        .rx_count(rxc9),
        .tx_level(tx_level),
        .rx_level(rx_level),
        .tx_trig(tx_trig),
        .rx_trig(rx_trig)
    );

    // Rising-edge trigger events; 256 mode adds empty and full as levels.
    assign ev = {mode_256 && rx_full, mode_256 && tx_empty,
        rx_trig && !rx_trig_q, tx_trig && !tx_trig_q};

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Each process below updates on every edge; a write lands at the edge that ends its strobe cycle.
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fcr_q <= `UPFC_RST_ZERO;
            lcr_q <= `UPFC_RST_ZERO;
            mcr_q <= `UPFC_RST_ZERO;
            efr_q <= `UPFC_RST_ZERO;
            page_open_q <= 1'b0;
            afr_q <= `UPFC_RST_ZERO;
            ttr_q <= `UPFC_RST_TRIG;
            rtr_q <= `UPFC_RST_TRIG;
            fur_q <= `UPFC_RST_ZERO;
            flr_q <= `UPFC_RST_ZERO;
            xon_q <= `UPFC_RST_ZERO;
        end
        else
        begin
            // Line control is always reachable so the host can leave pages.
            if (reg_wr && reg_addr == `UPFC_OFF_LCR)
            begin
                lcr_q <= reg_wdata;
            end
            // Modem control stays reachable on every non-extended page.
            if (reg_wr && !lcr_ext && reg_addr == `UPFC_OFF_MCR)
            begin
                if (efr_q[`UPFC_EFR_ENH])
                begin
                    mcr_q <= reg_wdata;
                end
                else
                begin
                    mcr_q <= {mcr_q[7], reg_wdata[6:0]};
                end
                if (alt_sel && reg_wdata[`UPFC_MCR_ALT])
                begin
                    xon_q <= {7'h00, reg_wdata[`UPFC_MCR_XOFF]};
                end
            end
            if (base_wr && reg_addr == `UPFC_OFF_FCR_ISR)
            begin
                fcr_q <= reg_wdata;
            end
            if (reg_wr && lcr_ext)
            begin
                if (reg_addr == `UPFC_OFF_PSR)
                begin
                    if (reg_wdata == `UPFC_PSR_OPEN)
                    begin
                        page_open_q <= 1'b1;
                    end
                    else if (reg_wdata == `UPFC_PSR_CLOSE)
                    begin
                        page_open_q <= 1'b0;
                    end
                end
                else if (!page_open_q && reg_addr == `UPFC_OFF_EFR)
                begin
                    efr_q <= reg_wdata;
                end
            end
            if (wr_ext)
            begin
                case (reg_addr)
                    `UPFC_OFF_AFR: afr_q <= reg_wdata;
                    `UPFC_OFF_TTR: ttr_q <= reg_wdata;
                    `UPFC_OFF_RTR: rtr_q <= reg_wdata;
                    `UPFC_OFF_FUR: fur_q <= reg_wdata;
                    `UPFC_OFF_FLR:
                    begin
                        if (mode_256 && (efr_q[`UPFC_EFR_SWTX] ||
                            efr_q[`UPFC_EFR_ARTS]) && reg_wdata < fur_q)
                        begin
                            flr_q <= reg_wdata;
                        end
                    end
                    default:
                    begin
                        flr_q <= flr_q;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    // A new event beats a write-one clear in the same cycle.
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ists_q <= 4'h0;
            imsk_q <= 4'h0;
            tx_trig_q <= 1'b0;
            rx_trig_q <= 1'b0;
        end
        else
        begin
            tx_trig_q <= tx_trig;
            rx_trig_q <= rx_trig;
            if (wr_alt && reg_addr == `UPFC_OFF_IRQ_STAT)
            begin
                ists_q <= (ists_q & ~reg_wdata[3:0]) | ev;
            end
            else
            begin
                ists_q <= ists_q | ev;
            end
            if (wr_alt && reg_addr == `UPFC_OFF_IRQ_MASK)
            begin
                imsk_q <= reg_wdata[3:0];
            end
        end
    end

    assign irq = |(ists_q & imsk_q);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    // Reads cause no side effects here; data lands one cycle later.
    always @*
    begin
        rdata_d = 8'h00;
        if (reg_rd && reg_addr == `UPFC_OFF_LCR)
        begin
            rdata_d = lcr_q;
        end
        else if (reg_rd && ext_sel)
        begin
            case (reg_addr)
                `UPFC_OFF_AFR: rdata_d = afr_q;
                `UPFC_OFF_TTR: rdata_d = ttr_q;
                `UPFC_OFF_RTR: rdata_d = rtr_q;
                `UPFC_OFF_FUR: rdata_d = fur_q;
                `UPFC_OFF_FLR: rdata_d = flow_lower;
                `UPFC_OFF_PSR: rdata_d = `UPFC_PSR_OPEN;
                default: rdata_d = 8'h00;
            endcase
        end
        else if (reg_rd && lcr_ext)
        begin
            case (reg_addr)
                `UPFC_OFF_EFR: rdata_d = efr_q;
                `UPFC_OFF_PSR: rdata_d = `UPFC_PSR_CLOSE;
                default: rdata_d = 8'h00;
            endcase
        end
        else if (reg_rd && alt_sel)
        begin
            case (reg_addr)
                `UPFC_OFF_TXCNT: rdata_d = sat8(txc9);
                `UPFC_OFF_RXCNT: rdata_d = sat8(rxc9);
                `UPFC_OFF_FSR: rdata_d = flow_status;
                `UPFC_OFF_MCR: rdata_d = mcr_q;
                `UPFC_OFF_IRQ_STAT: rdata_d = {4'h0, ists_q};
                `UPFC_OFF_IRQ_MASK: rdata_d = {4'h0, imsk_q};
                default: rdata_d = 8'h00;
            endcase
        end
        else if (reg_rd && reg_addr == `UPFC_OFF_MCR)
        begin
            rdata_d = mcr_q;
        end
        else if (reg_rd && reg_addr == `UPFC_OFF_FCR_ISR)
        begin
            rdata_d = base_rdata;
            if (mode_256)
            begin
                rdata_d[7] = tx_empty;
                rdata_d[6] = rx_full;
            end
        end
        else if (reg_rd)
        begin
            rdata_d = base_rdata;
        end
    end

    // Read data is held only for the cycle after the strobe.
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= rdata_d;
        end
    end
endmodule

// file: logic/upfc_level.v
// Purpose: Selects the active trigger levels and flags fills at or past them.
// Assumes: Counts and levels are in FIFO entries on one clock.
// Notes:   Purely combinational; the caller registers what it needs.
`timescale 1ns/100ps
`include "upfc_regs.vh"

module upfc_level
(
    fcr_top, // FIFO control bits 7:4.
    fifo_en, // FIFO enable bit.
    mode_256, // 256-byte mode selected.
    ttr_val, // Programmed TX trigger.
    rtr_val, // Programmed RX trigger.
    tx_count, // TX FIFO fill level.
    rx_count, // RX FIFO fill level.
    tx_level, // Active TX trigger level.
    rx_level, // Active RX trigger level.
    tx_trig, // TX fill at or below level.
    rx_trig // RX fill at or above level.
);
    input wire [3:0] fcr_top;
    input wire fifo_en;
    input wire mode_256;
    input wire [7:0] ttr_val;
    input wire [7:0] rtr_val;
    input wire [8:0] tx_count;
    input wire [8:0] rx_count;
    output reg [8:0] tx_level;
    output reg [8:0] rx_level;
    output wire tx_trig;
    output wire rx_trig;

    // ------------------------------------------------------------------
    // Level selection
    // ------------------------------------------------------------------
    // Fixed encodings serve 64-byte mode; programmed values in 256 mode.
    always @*
    begin
        case (fcr_top[3:2])
            2'b00: rx_level = `UPFC_RX_T0;
            2'b01: rx_level = `UPFC_RX_T1;
            2'b10: rx_level = `UPFC_RX_T2;
            default: rx_level = `UPFC_RX_T3;
        endcase
        case (fcr_top[1:0])
            2'b00: tx_level = `UPFC_TX_T0;
            2'b01: tx_level = `UPFC_TX_T1;
            2'b10: tx_level = `UPFC_TX_T2;
            default: tx_level = `UPFC_TX_T3;
        endcase
        if (mode_256)
        begin
            tx_level = {1'b0, ttr_val};
            rx_level = {1'b0, rtr_val};
        end
    end

    assign tx_trig = fifo_en && (tx_count <= tx_level);
    assign rx_trig = fifo_en && (rx_count >= rx_level);
endmodule
